// ===== core/adcs_clkdiv.sv
// conversion clock enable divider: one-cycle pulse every 2, 8 or 32 mclk cycles
// assumes mclk is the system clock and rst_n is synchronous active low
`timescale 1ns/1ps
`include "adcs_defs.svh"

module adcs_clkdiv (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [1:0] div_sel,
   output logic conv_tick
);
   logic [4:0] cnt;
   wire [4:0] last_val;
   wire at_last;

   // ****************************************
   // divider
   // ****************************************
   // undefined code 11 falls back to divide by 32, slowest and safest
   assign last_val = (div_sel == `ADCS_DIV_2) ? `ADCS_DIV2_LAST :
                     (div_sel == `ADCS_DIV_8) ? `ADCS_DIV8_LAST : `ADCS_DIV32_LAST;
   assign at_last = (cnt >= last_val);

   // counter held at zero while stopped so each conversion starts on a fresh phase
   always_ff @(posedge mclk) begin
      if (!rst_n || !run) begin
         cnt <= 5'h00;
         conv_tick <= 1'b0;
      end else begin
         cnt <= at_last ? 5'h00 : cnt + 5'h01;
         conv_tick <= at_last;
      end
   end

   chk_tick_spacing: assert property (@(posedge mclk) disable iff (!rst_n)
      (run && div_sel == `ADCS_DIV_2 && conv_tick) ##1 (run && div_sel == `ADCS_DIV_2) |-> !conv_tick)
      else $error("divide by two tick came back to back");
endmodule

// ===== core/adcs_defs.svh
// constants for the converter control sequencer: offsets, fields, reset values, timing
// assumes byte addresses on a 32-bit AHB-Lite slave, one word per register
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH

// ****************************************
// register indices and byte-address width
// ****************************************
`define ADCS_IDX_RES_LOW 8'h20
`define ADCS_IDX_RES_HIGH 8'h21
`define ADCS_IDX_CONTROL 8'h22
`define ADCS_IDX_CLK_SEL 8'h23
`define ADCS_ADDR_W 10

// ****************************************
// field positions
// ****************************************
`define ADCS_CHAN_LSB 0
`define ADCS_CHAN_MSB 2
`define ADCS_PCFG_LSB 3
`define ADCS_PCFG_MSB 5
`define ADCS_DONE_N_BIT 6
`define ADCS_START_BIT 7
`define ADCS_DIV_LSB 0
`define ADCS_DIV_MSB 1
`define ADCS_TEST_BIT 7

// ****************************************
// encodings and reset values
// ****************************************
`define ADCS_DIV_2 2'h0
`define ADCS_DIV_8 2'h1
`define ADCS_DIV_32 2'h2
`define ADCS_DIV2_LAST 5'h01
`define ADCS_DIV8_LAST 5'h07
`define ADCS_DIV32_LAST 5'h1F
`define ADCS_PCFG_OFF 3'h0
`define ADCS_PCFG_MAX 3'h5
`define ADCS_CHAN_MAX 3'h4
`define ADCS_CTRL_RESET 8'h00
`define ADCS_CSEL_RESET 8'h00
`define ADCS_RES_RESET 12'h000
`define ADCS_CONV_CYCLES 5'h10
`define ADCS_HTRANS_NONSEQ 2'h2
`define ADCS_HRESP_OKAY 1'b0

`endif

// ===== core/adcs_pkg.sv
// types shared by the converter control sequencer files
// assumes adcs_defs.svh is included by the modules that need constants
package adcs_pkg;
   // sequencer states, one-hot
   typedef enum logic [2:0] {
      ADCS_IDLE = 3'h1,
      ADCS_ARMED = 3'h2,
      ADCS_CONV = 3'h4
   } adcs_state_t;
endpackage

// ===== core/adcs_top.sv
// converter control sequencer: AHB-Lite register slave, start sequencing, result bytes, port-B routing
// assumes one clock mclk, synchronous active-low rst_n, a single AHB-Lite master doing word transfers
`timescale 1ns/1ps
`include "adcs_defs.svh"

module adcs_top #(
   parameter int CHANNELS = 5,
   parameter int RES_W = 12
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [RES_W-1:0] core_result,
   output logic core_power_on,
   output logic core_reset,
   output logic core_sample,
   output logic [CHANNELS-1:0] chan_route,
   output logic [CHANNELS-1:0] portb_analog,
   output logic [CHANNELS-1:0] portb_digital_en,
   output logic [CHANNELS-1:0] portb_pullup_en,
   output logic conv_irq_request
);
   // ****************************************
   // registers and state
   // ****************************************
   logic [2:0] chan_sel;
   logic [2:0] portb_cfg;
   logic start_bit;
   logic conv_done_n;
   logic [1:0] conv_clk_div;
   logic test_bit;
   logic [RES_W-1:0] result;
   logic [4:0] tick_cnt;
   logic wr_pend;
   logic [7:0] wr_idx;
   adcs_pkg::adcs_state_t state;
   adcs_pkg::adcs_state_t next_state;
   logic conv_tick;

   // expand a port-B code into a mask of analog lines, lines 0..k-1; codes above 5 give no analog lines
   function automatic logic [CHANNELS-1:0] adcs_lines(input logic [2:0] k);
      logic [CHANNELS-1:0] m;
      m = '0;
      for (int i = 0; i < CHANNELS; i++) begin
         if (i < int'(k) && k <= `ADCS_PCFG_MAX) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // ****************************************
   // bus decode
   // ****************************************
   wire addr_ok = hsel && hready && htrans == `ADCS_HTRANS_NONSEQ;
   wire [7:0] bus_idx = haddr[`ADCS_ADDR_W-1:2];
   wire wr_data_phase = wr_pend;
   wire wr_ctrl = wr_data_phase && wr_idx == `ADCS_IDX_CONTROL;
   wire wr_csel = wr_data_phase && wr_idx == `ADCS_IDX_CLK_SEL;
   wire [7:0] wbyte = hwdata[7:0];
   wire next_start = wr_ctrl ? wbyte[`ADCS_START_BIT] : start_bit;
   wire start_rise = !start_bit && next_start;
   wire start_fall = start_bit && !next_start;
   wire [2:0] next_pcfg = wr_ctrl ? wbyte[`ADCS_PCFG_MSB:`ADCS_PCFG_LSB] : portb_cfg;
   wire [7:0] ctrl_rd = {start_bit, conv_done_n, portb_cfg, chan_sel};
   wire [7:0] csel_rd = {test_bit, 5'h00, conv_clk_div};
   wire [7:0] low_rd = {result[3:0], 4'h0};
   wire [7:0] high_rd = result[RES_W-1:4];
   // unmapped offsets read zero and answer OKAY
   wire [7:0] rd_sel = (bus_idx == `ADCS_IDX_RES_LOW) ? low_rd :
                       (bus_idx == `ADCS_IDX_RES_HIGH) ? high_rd :
                       (bus_idx == `ADCS_IDX_CONTROL) ? ctrl_rd :
                       (bus_idx == `ADCS_IDX_CLK_SEL) ? csel_rd : 8'h00;
   wire conv_last = conv_tick && tick_cnt == `ADCS_CONV_CYCLES - 5'h01;
   wire powered = portb_cfg != `ADCS_PCFG_OFF;

   // write data phase is the cycle after the address phase; zero-wait slave
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_pend <= 1'b0;
         wr_idx <= 8'h00;
         hrdata <= 32'h00000000;
      end else begin
         wr_pend <= addr_ok && hwrite;
         wr_idx <= bus_idx;
         hrdata <= (addr_ok && !hwrite) ? {24'h000000, rd_sel} : 32'h00000000;
      end
   end

   // constant answer, the slave never stalls or errors
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= `ADCS_HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp <= `ADCS_HRESP_OKAY;
      end
   end

   // ****************************************
   // software registers
   // ****************************************
   // result offsets fall through untouched, so writes there do nothing
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         chan_sel <= 3'(`ADCS_CTRL_RESET);
         portb_cfg <= `ADCS_PCFG_OFF;
         start_bit <= 1'b0;
         conv_clk_div <= `ADCS_DIV_2;
         test_bit <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            chan_sel <= wbyte[`ADCS_CHAN_MSB:`ADCS_CHAN_LSB];
            portb_cfg <= next_pcfg;
            start_bit <= next_start;
         end
         if (wr_csel) begin
            conv_clk_div <= wbyte[`ADCS_DIV_MSB:`ADCS_DIV_LSB];
            test_bit <= wbyte[`ADCS_TEST_BIT]; // held only, no test logic
         end
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   // a fall without a prior rise cannot occur since rise always arms first
   always_comb begin
      next_state = state;
      unique case (state)
         adcs_pkg::ADCS_IDLE: begin
            if (start_rise) next_state = adcs_pkg::ADCS_ARMED;
         end
         adcs_pkg::ADCS_ARMED: begin
            if (start_fall) next_state = powered ? adcs_pkg::ADCS_CONV : adcs_pkg::ADCS_IDLE;
         end
         adcs_pkg::ADCS_CONV: begin
            if (start_rise) next_state = adcs_pkg::ADCS_ARMED; // restart aborts
            else if (conv_last) next_state = adcs_pkg::ADCS_IDLE;
            else if (!powered) next_state = adcs_pkg::ADCS_IDLE;
         end
         default: next_state = adcs_pkg::ADCS_IDLE;
      endcase
   end

   // state, tick count and converter strobes
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state <= adcs_pkg::ADCS_IDLE;
         tick_cnt <= 5'h00;
         core_reset <= 1'b0;
         core_sample <= 1'b0;
      end else begin
         state <= next_state;
         tick_cnt <= (state != adcs_pkg::ADCS_CONV) ? 5'h00 : (conv_tick ? tick_cnt + 5'h01 : tick_cnt);
         core_reset <= start_rise;
         core_sample <= conv_last;
      end
   end

   // done_n: rise sets, finish clears, nothing else moves it
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         conv_done_n <= 1'b0;
      end else if (start_rise) begin
         conv_done_n <= 1'b1;
      end else if (state == adcs_pkg::ADCS_CONV && conv_last) begin
         conv_done_n <= 1'b0;
      end
   end

   // result captured in the finishing cycle, then held
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         result <= `ADCS_RES_RESET;
      end else if (state == adcs_pkg::ADCS_CONV && conv_last) begin
         result <= core_result;
      end
   end

   // request pulse to the interrupt controller, which holds the sticky flag
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         conv_irq_request <= 1'b0;
      end else begin
         conv_irq_request <= state == adcs_pkg::ADCS_CONV && conv_last;
      end
   end

   // ****************************************
   // pin routing and power
   // ****************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         core_power_on <= 1'b0;
         portb_analog <= '0;
         portb_digital_en <= '1;
         portb_pullup_en <= '1;
         chan_route <= '0;
      end else begin
         core_power_on <= next_pcfg != `ADCS_PCFG_OFF;
         portb_analog <= adcs_lines(next_pcfg);
         portb_digital_en <= ~adcs_lines(next_pcfg);
         portb_pullup_en <= ~adcs_lines(next_pcfg);
         chan_route <= (chan_sel <= `ADCS_CHAN_MAX) ? CHANNELS'(1) << chan_sel : '0;
      end
   end

   adcs_clkdiv u_clkdiv (
      .mclk(mclk),
      .rst_n(rst_n),
      .run(state == adcs_pkg::ADCS_CONV),
      .div_sel(conv_clk_div),
      .conv_tick(conv_tick)
   );

   // ****************************************
   // checks
   // ****************************************
   chk_rise_sets_done: assert property (@(posedge mclk) disable iff (!rst_n)
      start_rise |=> conv_done_n && core_reset)
      else $error("start rise did not set done_n");
   chk_fall_launches: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == adcs_pkg::ADCS_ARMED && start_fall && powered) |=> state == adcs_pkg::ADCS_CONV)
      else $error("start fall did not launch");
   chk_finish_clears: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == adcs_pkg::ADCS_CONV && conv_last && !start_rise) |=> !conv_done_n && conv_irq_request)
      else $error("finish did not clear done_n and request");
   chk_power_off: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_ctrl && next_pcfg == `ADCS_PCFG_OFF) |=> !core_power_on && portb_analog == '0)
      else $error("converter not powered off");
   chk_csel_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      (addr_ok && !hwrite && bus_idx == `ADCS_IDX_CLK_SEL) |=> hrdata[6:2] == 5'h00)
      else $error("unused clock-select bits read nonzero");
   chk_low_pack: assert property (@(posedge mclk) disable iff (!rst_n)
      (addr_ok && !hwrite && bus_idx == `ADCS_IDX_RES_LOW) |=> hrdata[7:0] == {$past(result[3:0]), 4'h0})
      else $error("low result byte misformatted");
   chk_result_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == adcs_pkg::ADCS_IDLE) |=> $stable(result))
      else $error("result moved while idle");
   chk_done_stable: assert property (@(posedge mclk) disable iff (!rst_n)
      (!start_rise && !(state == adcs_pkg::ADCS_CONV && conv_last)) |=> $stable(conv_done_n))
      else $error("done_n moved without cause");
   chk_pins_digital: assert property (@(posedge mclk) disable iff (!rst_n)
      ##1 (portb_analog & (portb_digital_en | portb_pullup_en)) == '0)
      else $error("analog line left digital");
   cov_conversion: cover property (@(posedge mclk) disable iff (!rst_n) conv_irq_request);
   cov_restart: cover property (@(posedge mclk) disable iff (!rst_n) state == adcs_pkg::ADCS_CONV && start_rise);
   cov_power_abort: cover property (@(posedge mclk) disable iff (!rst_n) state == adcs_pkg::ADCS_CONV && !powered);
endmodule

// ===== verif/adc_control_sequencer_bench.sv
// self-checking bench for the converter control sequencer, driven over AHB-Lite
// assumes adcs_top with its hand-over timing and the analog model beside it
`timescale 1ns/1ps
`include "adcs_defs.svh"

module adc_control_sequencer_bench;
   localparam logic [31:0] A_LO = {22'h0, `ADCS_IDX_RES_LOW, 2'h0};
   localparam logic [31:0] A_HI = {22'h0, `ADCS_IDX_RES_HIGH, 2'h0};
   localparam logic [31:0] A_CT = {22'h0, `ADCS_IDX_CONTROL, 2'h0};
   localparam logic [31:0] A_CS = {22'h0, `ADCS_IDX_CLK_SEL, 2'h0};
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [11:0] core_result;
   logic core_power_on, core_reset, core_sample, conv_irq_request;
   logic [4:0] chan_route, portb_analog, portb_digital_en, portb_pullup_en;
   logic [31:0] r;
   logic [11:0] e;
   logic [4:0] ana;
   int resets = 0;
   int samples = 0;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   int irqs = 0;
   int n0, n, dv, rs0;

   adcs_top uut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .core_result(core_result),
      .core_power_on(core_power_on), .core_reset(core_reset), .core_sample(core_sample),
      .chan_route(chan_route), .portb_analog(portb_analog), .portb_digital_en(portb_digital_en),
      .portb_pullup_en(portb_pullup_en), .conv_irq_request(conv_irq_request));

   adcs_analog_model model (.mclk(mclk), .core_power_on(core_power_on), .chan_route(chan_route),
      .core_result(core_result));

   always #20 mclk = ~mclk;

   // ****************************************
   // monitors and timeout
   // ****************************************
   // strobes last one cycle, so latch them here instead of polling
   always @(posedge mclk) begin
      cycles++;
      if (core_reset === 1'b1) resets++;
      if (core_sample === 1'b1) samples++;
      if (conv_irq_request === 1'b1) irqs++;
      if (cycles == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         $display("wrong value %s expected %h seen %h", nm, ex, got);
         miscompares++;
      end
   endtask

   // single word transfer; hold each phase until hready is seen high
   task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= `ADCS_HTRANS_NONSEQ;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("bus response", 32'(`ADCS_HRESP_OKAY), 32'(hresp));
   endtask

   task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] ex);
      logic [31:0] v;
      bus(1'b0, a, 8'h00, v);
      chk(nm, ex, v);
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rchk("result low", A_LO, 32'h0);
      rchk("result high", A_HI, 32'h0);
      rchk("control", A_CT, 32'h0);
      rchk("clock select", A_CS, 32'h0);
      $display("test reset values done");
      // unused clock-select bits must read zero; test bit is kept
      bus(1'b1, A_CS, 8'hFF, r);
      rchk("clock select", A_CS, 32'h83);
      bus(1'b1, 32'h90, 8'hFF, r);
      rchk("unmapped", 32'h90, 32'h0);
      $display("test clock select done");
      // every port-B and channel code, including the undefined ones
      for (int v = 0; v < 8; v++) begin
         bus(1'b1, A_CT, {2'b00, 3'(v), 3'(v)}, r);
         repeat (2) @(posedge mclk);
         ana = (v >= 1 && v <= 5) ? 5'((1 << v) - 1) : 5'h00;
         chk("portb analog", 32'(ana), 32'(portb_analog));
         chk("digital enable", {27'h0, ~ana}, 32'(portb_digital_en));
         chk("pullup enable", {27'h0, ~ana}, 32'(portb_pullup_en));
         chk("power", 32'(v != 0), 32'(core_power_on));
         chk("route", (v < 5) ? 32'(1 << v) : 32'h0, 32'(chan_route));
      end
      $display("test port config done");
      // one conversion per channel; dividers cycle through all four codes
      for (int i = 0; i < 5; i++) begin
         dv = (i % 4 == 0) ? 2 : (i % 4 == 1) ? 8 : 32;
         e = 12'h3C5 + 12'(i) * 12'h111;
         bus(1'b1, A_CS, 8'(i % 4), r); // test bit left clear
         bus(1'b1, A_CT, {2'b00, 3'h5, 3'(i)}, r);
         rs0 = resets;
         bus(1'b1, A_CT, {2'b10, 3'h5, 3'(i)}, r);
         n0 = irqs;
         // fall must follow the port-B change within 40 system clocks
         repeat (20) @(posedge mclk);
         chk("core reset seen", 32'(rs0 + 1), 32'(resets));
         chk("no launch on rise", 32'(n0), 32'(irqs));
         bus(1'b1, A_CT, {2'b00, 3'h5, 3'(i)}, r);
         rchk("control busy", A_CT, 32'h68 | 32'(i));
         n = 2;
         while (conv_irq_request !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            n++;
         end
         @(posedge mclk);
         chk("conversion time", 32'h1, 32'(n >= 15 * dv && n <= 17 * dv + 8));
         chk("irq pulses", 32'(n0 + 1), 32'(irqs));
         chk("sample pulses", 32'(irqs), 32'(samples));
         rchk("control done", A_CT, 32'h28 | 32'(i));
         rchk("result high", A_HI, {24'h0, e[11:4]});
         rchk("result low", A_LO, {24'h0, e[3:0], 4'h0});
         bus(1'b1, A_HI, 8'hFF, r);
         bus(1'b1, A_LO, 8'hFF, r);
         rchk("result high kept", A_HI, {24'h0, e[11:4]});
         rchk("result low kept", A_LO, {24'h0, e[3:0], 4'h0});
         $display("test conversion %0d done", i);
      end
      // start pulse with port B all digital must not convert
      bus(1'b1, A_CS, 8'h00, r);
      bus(1'b1, A_CT, 8'h80, r);
      bus(1'b1, A_CT, 8'h00, r);
      n0 = irqs;
      repeat (60) @(posedge mclk);
      chk("no conversion powered off", 32'(n0), 32'(irqs));
      rchk("control idle", A_CT, 32'h40);
      $display("test powered off start done");
      // port B cleared mid-conversion powers down and abandons the conversion
      bus(1'b1, A_CS, 8'h02, r);
      bus(1'b1, A_CT, 8'h2C, r);
      bus(1'b1, A_CT, 8'hAC, r);
      bus(1'b1, A_CT, 8'h2C, r);
      n0 = irqs;
      rchk("control busy", A_CT, 32'h6C);
      repeat (100) @(posedge mclk);
      bus(1'b1, A_CT, 8'h00, r); // no start pulse needed
      repeat (600) @(posedge mclk);
      chk("no finish after abort", 32'(n0), 32'(irqs));
      chk("power after abort", 32'h0, 32'(core_power_on));
      rchk("control aborted", A_CT, 32'h40);
      rchk("result after abort", A_HI, {24'h0, e[11:4]});
      $display("test power abort done");
      report_and_stop();
   end
endmodule

// ===== verif/adcs_analog_model.sv
// model of the analog side: one fixed sample value per input line, picked by the channel route
// assumes chan_route is one-hot or zero and core_power_on gates the converter
`timescale 1ns/1ps

// ****************************************
// analog input model
// ****************************************
module adcs_analog_model (
   input wire logic mclk,
   input wire logic core_power_on,
   input wire logic [4:0] chan_route,
   output logic [11:0] core_result
);
   logic [11:0] line_val;

   // each line carries its own level so a wrong route shows up in the result
   always_comb begin
      line_val = 12'h000;
      for (int i = 0; i < 5; i++) begin
         if (chan_route[i]) begin
            line_val = 12'h3C5 + 12'(i) * 12'h111;
         end
      end
   end

   // unpowered or unrouted: toggle every cycle, so nothing stale looks valid
   initial core_result = 12'h000;
   always @(posedge mclk) begin
      if (core_power_on === 1'b1 && chan_route !== 5'h00) begin
         core_result <= line_val;
      end else begin
         core_result <= ~core_result;
      end
   end
endmodule
